// >>> verilog/pmac_cfg.svh
`ifndef PMAC_CFG_SVH
`define PMAC_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Bus geometry.
`define PMAC_ADDR_W             12
`define PMAC_DATA_W             32

////////////////////////////////////////////////////////////////////////////////
// Register offsets, byte addresses.
`define PMAC_OFS_CTRL           12'h000
`define PMAC_OFS_MC_TYPE        12'h004
`define PMAC_OFS_POLARITY       12'h008
`define PMAC_OFS_PRELOAD        12'h00C
`define PMAC_OFS_STATUS         12'h010
`define PMAC_FUSE_REGION        4'h1
`define PMAC_SIG_REGION         7'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define PMAC_CTRL_MODE_LSB      0
`define PMAC_CTRL_SECURE_BIT    2
`define PMAC_PRELOAD_VAL_LSB    0
`define PMAC_PRELOAD_MASK_LSB   8
`define PMAC_STATUS_Q_LSB       0
`define PMAC_STATUS_OE_LSB      8
`define PMAC_STATUS_SECURE_BIT  16
`define PMAC_STATUS_POR_BIT     17
`define PMAC_STATUS_MODE_LSB    18

////////////////////////////////////////////////////////////////////////////////
// Array geometry and reset values.
`define PMAC_NUM_MC             8
`define PMAC_NUM_PT             64
`define PMAC_PT_W               32
`define PMAC_SIG_BYTES          8
`define PMAC_MC_TYPE_RST        16'h0000
`define PMAC_POLARITY_RST       8'h00
`define PMAC_IO_OUT_RST         8'hFF
`define PMAC_FUSE_RST           32'hFFFFFFFF
`define PMAC_SIG_RST            8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing.
`define PMAC_POR_TIME_NS        1000
`define PMAC_CLK_PERIOD_NS      5
`define PMAC_POR_CYCLES         (`PMAC_POR_TIME_NS / `PMAC_CLK_PERIOD_NS)
`define PMAC_POR_CNT_W          8

`endif

// >>> verilog/pmac_pkg.sv
`include "pmac_cfg.svh"

package pmac_pkg;

    typedef enum logic [1:0] {
        PMAC_MODE_REGISTERED = 2'b00,
        PMAC_MODE_COMPLEX    = 2'b01,
        PMAC_MODE_SIMPLE     = 2'b10
    } pmac_mode_t;

    typedef enum logic [1:0] {
        PMAC_MC_INPUT    = 2'b00,
        PMAC_MC_REG_OUT  = 2'b01,
        PMAC_MC_COMB_IO  = 2'b10,
        PMAC_MC_COMB_OUT = 2'b11
    } pmac_mc_type_t;

    typedef enum logic {
        PMAC_POR_HOLD = 1'b0,
        PMAC_POR_RUN  = 1'b1
    } pmac_por_t;

    typedef enum logic [1:0] {
        PMAC_RD_NONE = 2'b00,
        PMAC_RD_REG  = 2'b01,
        PMAC_RD_FUSE = 2'b10,
        PMAC_RD_SIG  = 2'b11
    } pmac_rd_src_t;

    typedef enum logic [1:0] {
        PMAC_DSEL_REG  = 2'b00,
        PMAC_DSEL_SUM7 = 2'b01,
        PMAC_DSEL_SUM8 = 2'b10
    } pmac_dsel_t;

    typedef enum logic [1:0] {
        PMAC_OSEL_OFF = 2'b00,
        PMAC_OSEL_ON  = 2'b01,
        PMAC_OSEL_PT  = 2'b10,
        PMAC_OSEL_PIN = 2'b11
    } pmac_osel_t;

    typedef struct packed {
        pmac_dsel_t dsel;
        pmac_osel_t osel;
    } pmac_drive_t;

    typedef struct packed {
        pmac_mode_t                  mode;
        logic                        secured;
        logic [15:0]                 mc_type;
        logic [7:0]                  polarity;
        logic [7:0]                  q;
        logic [7:0]                  io_out;
        logic [7:0]                  io_oe;
        logic                        clk_prev;
        pmac_por_t                   por;
        logic [`PMAC_POR_CNT_W-1:0]  por_cnt;
        pmac_rd_src_t                rd_src;
        logic [31:0]                 rd_word;
    } pmac_state_t;

endpackage

// >>> verilog/pmac_mem.sv
`timescale 1ns/1ps

module pmac_mem #(
    parameter int                 WIDTH     = 8,
    parameter int                 DEPTH     = 8,
    parameter int                 AW        = 3,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         wr_en,
    input  wire logic [AW-1:0]                wr_addr,
    input  wire logic [WIDTH-1:0]             wr_data,
    input  wire logic                         rd_en,
    input  wire logic [AW-1:0]                rd_addr,
    output logic      [WIDTH-1:0]             rd_data,
    output logic      [DEPTH-1:0][WIDTH-1:0]  contents
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0]            rd_data;
    } pmac_mem_state_t;

    localparam pmac_mem_state_t MEM_RESET = '{words: {DEPTH{RESET_VAL}}, rd_data: '0};

    pmac_mem_state_t mem_reg;
    pmac_mem_state_t mem_next;

    ////////////////////////////////////////////////////////////////////////////
    // Read data is registered so that it stands only in the cycle after the strobe.
    always_comb begin
        mem_next = mem_reg;
        mem_next.rd_data = '0;
        if (wr_en) begin
            mem_next.words[wr_addr] = wr_data;
        end
        if (rd_en) begin
            mem_next.rd_data = mem_reg.words[rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mem_reg <= MEM_RESET;
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rd_data  = mem_reg.rd_data;
    assign contents = mem_reg.words;

endmodule

// >>> verilog/pmac_array.sv
`timescale 1ns/1ps
`include "pmac_cfg.svh"

module pmac_array
    import pmac_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic [`PMAC_ADDR_W-1:0]  bus_addr,
    input  wire logic [`PMAC_DATA_W-1:0]  bus_wdata,
    input  wire logic                     bus_wr,
    input  wire logic                     bus_rd,
    output logic      [`PMAC_DATA_W-1:0]  bus_rdata,
    input  wire logic                     pin_clk_in,
    input  wire logic                     pin_clk_drv,
    input  wire logic                     pin_oe_n_in,
    input  wire logic                     pin_oe_n_drv,
    input  wire logic [7:0]               ded_in,
    input  wire logic [7:0]               ded_drv,
    input  wire logic [7:0]               io_in,
    input  wire logic [7:0]               io_drv,
    output logic      [7:0]               io_out,
    output logic      [7:0]               io_oe
);

    localparam logic [`PMAC_POR_CNT_W-1:0] POR_LAST =
        `PMAC_POR_CNT_W'(`PMAC_POR_CYCLES - 1);

    localparam pmac_state_t ST_RESET = '{
        mode:     PMAC_MODE_REGISTERED,
        secured:  1'b0,
        mc_type:  `PMAC_MC_TYPE_RST,
        polarity: `PMAC_POLARITY_RST,
        q:        8'h00,
        io_out:   `PMAC_IO_OUT_RST,
        io_oe:    8'h00,
        clk_prev: 1'b1,
        por:      PMAC_POR_HOLD,
        por_cnt:  8'h00,
        rd_src:   PMAC_RD_NONE,
        rd_word:  32'h00000000
    };

    pmac_state_t st_reg;
    pmac_state_t st_next;

    logic                                 pin_clk_lvl;
    logic                                 pin_oe_n_lvl;
    logic [7:0]                           ded_lvl;
    logic [7:0]                           io_lvl;
    logic [7:0]                           col;
    logic [15:0]                          sig;
    logic [31:0]                          lits;
    logic [7:0]                           sum8;
    logic [7:0]                           sum7;
    logic [7:0]                           pt_oe;
    pmac_drive_t [7:0]                    drive;
    logic                                 in_fuse;
    logic                                 in_sig;
    logic [`PMAC_NUM_PT-1:0][31:0]        fuse_words;
    logic [31:0]                          fuse_rd;
    logic [7:0]                           sig_rd;
    logic [`PMAC_SIG_BYTES-1:0][7:0]      sig_words;
    logic                                 clk_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding shared by several places.

    function automatic pmac_mc_type_t mc_kind(input logic [15:0] types, input int idx);
        mc_kind = pmac_mc_type_t'(types[2*idx +: 2]);
    endfunction

    function automatic pmac_drive_t mc_drive(
        input pmac_mode_t    mode,
        input pmac_mc_type_t kind,
        input logic          inner
    );
        mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_OFF};
        case (mode)
            PMAC_MODE_REGISTERED: begin
                case (kind)
                    PMAC_MC_REG_OUT:  mc_drive = '{dsel: PMAC_DSEL_REG,  osel: PMAC_OSEL_PIN};
                    PMAC_MC_COMB_IO:  mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_PT};
                    PMAC_MC_COMB_OUT: mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_ON};
                    default:          mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_OFF};
                endcase
            end
            PMAC_MODE_COMPLEX: begin
                case (kind)
                    PMAC_MC_INPUT:    mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_OFF};
                    PMAC_MC_COMB_OUT: mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_ON};
                    default:          mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_PT};
                endcase
            end
            PMAC_MODE_SIMPLE: begin
                if (inner) begin
                    mc_drive = '{dsel: PMAC_DSEL_SUM8, osel: PMAC_OSEL_ON};
                end else if (kind == PMAC_MC_INPUT) begin
                    mc_drive = '{dsel: PMAC_DSEL_SUM8, osel: PMAC_OSEL_OFF};
                end else begin
                    mc_drive = '{dsel: PMAC_DSEL_SUM8, osel: PMAC_OSEL_ON};
                end
            end
            default: mc_drive = '{dsel: PMAC_DSEL_SUM7, osel: PMAC_OSEL_OFF};
        endcase
    endfunction

    // Pins one and eleven never reach the array in registered mode, so the
    // outer columns there carry cell feedback like the others.
    function automatic logic col_select(
        input pmac_mode_t    mode,
        input pmac_mc_type_t kind,
        input int            idx,
        input logic          q_bit,
        input logic [7:0]    pins,
        input logic          pin1,
        input logic          pin11
    );
        case (mode)
            PMAC_MODE_REGISTERED: begin
                col_select = (kind == PMAC_MC_REG_OUT) ? q_bit : pins[idx];
            end
            PMAC_MODE_COMPLEX: begin
                if (idx == 0) begin
                    col_select = pin11;
                end else if (idx == 7) begin
                    col_select = pin1;
                end else begin
                    col_select = pins[idx];
                end
            end
            PMAC_MODE_SIMPLE: begin
                if (idx == 0) begin
                    col_select = pin11;
                end else if (idx == 7) begin
                    col_select = pin1;
                end else if (idx < 4) begin
                    col_select = pins[idx-1];
                end else begin
                    col_select = pins[idx+1];
                end
            end
            default: col_select = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin levels with weak pull-ups.

    assign pin_clk_lvl  = pin_clk_drv  ? pin_clk_in  : 1'b1;
    assign pin_oe_n_lvl = pin_oe_n_drv ? pin_oe_n_in : 1'b1;
    assign ded_lvl      = (ded_in & ded_drv) | ~ded_drv;

    // Own drive wins over an external driver; the registered copy of the pin
    // breaks what would otherwise be a combinational loop through the array.
    assign io_lvl = (st_reg.io_oe & st_reg.io_out)
                  | (~st_reg.io_oe & ((io_in & io_drv) | ~io_drv));

    assign clk_rise = pin_clk_lvl & ~st_reg.clk_prev;

    ////////////////////////////////////////////////////////////////////////////
    // AND-OR array.

    assign sig = {col, ded_lvl};

    generate
        for (genvar k = 0; k < 16; k++) begin : g_lit
            assign lits[2*k]   = sig[k];
            assign lits[2*k+1] = ~sig[k];
        end
        for (genvar m = 0; m < `PMAC_NUM_MC; m++) begin : g_mc
            localparam logic INNER = (m == 3) || (m == 4);
            logic [7:0] pt;
            for (genvar p = 0; p < 8; p++) begin : g_pt
                assign pt[p] = &(lits | ~fuse_words[m*8+p]);
            end
            assign sum8[m]  = |pt;
            assign sum7[m]  = |pt[7:1];
            assign pt_oe[m] = pt[0];
            assign drive[m] = mc_drive(st_reg.mode, mc_kind(st_reg.mc_type, m), INNER);
            assign col[m]   = col_select(st_reg.mode, mc_kind(st_reg.mc_type, m), m,
                                         st_reg.q[m], io_lvl, pin_clk_lvl, pin_oe_n_lvl);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and storage.

    assign in_fuse = (bus_addr[11:8] == `PMAC_FUSE_REGION);
    assign in_sig  = (bus_addr[11:5] == `PMAC_SIG_REGION);

    pmac_mem #(
        .WIDTH     (`PMAC_PT_W),
        .DEPTH     (`PMAC_NUM_PT),
        .AW        (6),
        .RESET_VAL (`PMAC_FUSE_RST)
    ) u_fuse (
        .clk      (clk),
        .reset    (reset),
        .wr_en    (bus_wr & in_fuse),
        .wr_addr  (bus_addr[7:2]),
        .wr_data  (bus_wdata),
        .rd_en    (bus_rd & in_fuse & ~st_reg.secured),
        .rd_addr  (bus_addr[7:2]),
        .rd_data  (fuse_rd),
        .contents (fuse_words)
    );

    pmac_mem #(
        .WIDTH     (8),
        .DEPTH     (`PMAC_SIG_BYTES),
        .AW        (3),
        .RESET_VAL (`PMAC_SIG_RST)
    ) u_sig (
        .clk      (clk),
        .reset    (reset),
        .wr_en    (bus_wr & in_sig),
        .wr_addr  (bus_addr[4:2]),
        .wr_data  (bus_wdata[7:0]),
        .rd_en    (bus_rd & in_sig),
        .rd_addr  (bus_addr[4:2]),
        .rd_data  (sig_rd),
        .contents (sig_words)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_next = st_reg;
        st_next.rd_src = PMAC_RD_NONE;
        st_next.rd_word = 32'h00000000;
        st_next.clk_prev = pin_clk_lvl;

        case (st_reg.por)
            PMAC_POR_HOLD: begin
                // Clock edges are ignored here; the registers are held low whatever the pin does.
                st_next.q = 8'h00;
                if (st_reg.por_cnt == POR_LAST) begin
                    st_next.por = PMAC_POR_RUN;
                end else begin
                    st_next.por_cnt = st_reg.por_cnt + 8'h01;
                end
            end
            PMAC_POR_RUN: begin
                if (clk_rise && st_reg.mode == PMAC_MODE_REGISTERED) begin
                    for (int i = 0; i < `PMAC_NUM_MC; i++) begin
                        if (mc_kind(st_reg.mc_type, i) == PMAC_MC_REG_OUT) begin
                            st_next.q[i] = sum8[i];
                        end
                    end
                end
            end
            default: st_next.por = PMAC_POR_HOLD;
        endcase

        if (bus_wr) begin
            case (bus_addr)
                `PMAC_OFS_CTRL: begin
                    if (bus_wdata[`PMAC_CTRL_MODE_LSB +: 2] != 2'h3) begin
                        st_next.mode = pmac_mode_t'(bus_wdata[`PMAC_CTRL_MODE_LSB +: 2]);
                    end
                    if (bus_wdata[`PMAC_CTRL_SECURE_BIT]) begin
                        st_next.secured = 1'b1;
                    end
                end
                `PMAC_OFS_MC_TYPE: st_next.mc_type = bus_wdata[15:0];
                `PMAC_OFS_POLARITY: st_next.polarity = bus_wdata[7:0];
                `PMAC_OFS_PRELOAD: begin
                    // Preload beats a clock rise in the same cycle.
                    if (!st_reg.secured && st_reg.por == PMAC_POR_RUN) begin
                        for (int i = 0; i < `PMAC_NUM_MC; i++) begin
                            if (bus_wdata[`PMAC_PRELOAD_MASK_LSB + i]) begin
                                st_next.q[i] = bus_wdata[`PMAC_PRELOAD_VAL_LSB + i];
                            end
                        end
                    end
                end
                default: ;
            endcase
        end

        for (int i = 0; i < `PMAC_NUM_MC; i++) begin
            case (drive[i].dsel)
                PMAC_DSEL_REG:  st_next.io_out[i] = ~st_reg.q[i];
                PMAC_DSEL_SUM8: st_next.io_out[i] = sum8[i] ^ st_reg.polarity[i];
                default:        st_next.io_out[i] = sum7[i] ^ st_reg.polarity[i];
            endcase
            case (drive[i].osel)
                PMAC_OSEL_ON:  st_next.io_oe[i] = 1'b1;
                PMAC_OSEL_PT:  st_next.io_oe[i] = pt_oe[i];
                PMAC_OSEL_PIN: st_next.io_oe[i] = ~pin_oe_n_lvl;
                default:       st_next.io_oe[i] = 1'b0;
            endcase
        end

        if (bus_rd) begin
            if (in_fuse) begin
                st_next.rd_src = st_reg.secured ? PMAC_RD_REG : PMAC_RD_FUSE;
            end else if (in_sig) begin
                st_next.rd_src = PMAC_RD_SIG;
            end else begin
                st_next.rd_src = PMAC_RD_REG;
                case (bus_addr)
                    `PMAC_OFS_CTRL: begin
                        st_next.rd_word[`PMAC_CTRL_MODE_LSB +: 2] = st_reg.mode;
                        st_next.rd_word[`PMAC_CTRL_SECURE_BIT] = st_reg.secured;
                    end
                    `PMAC_OFS_MC_TYPE: st_next.rd_word[15:0] = st_reg.mc_type;
                    `PMAC_OFS_POLARITY: st_next.rd_word[7:0] = st_reg.polarity;
                    `PMAC_OFS_STATUS: begin
                        st_next.rd_word[`PMAC_STATUS_Q_LSB +: 8] = st_reg.q;
                        st_next.rd_word[`PMAC_STATUS_OE_LSB +: 8] = st_reg.io_oe;
                        st_next.rd_word[`PMAC_STATUS_SECURE_BIT] = st_reg.secured;
                        st_next.rd_word[`PMAC_STATUS_POR_BIT] =
                            (st_reg.por == PMAC_POR_HOLD);
                        st_next.rd_word[`PMAC_STATUS_MODE_LSB +: 2] = st_reg.mode;
                    end
                    default: st_next.rd_word = 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_comb begin
        case (st_reg.rd_src)
            PMAC_RD_FUSE: bus_rdata = fuse_rd;
            PMAC_RD_SIG:  bus_rdata = {24'h000000, sig_rd};
            PMAC_RD_REG:  bus_rdata = st_reg.rd_word;
            default:      bus_rdata = 32'h00000000;
        endcase
    end

    assign io_out = st_reg.io_out;
    assign io_oe  = st_reg.io_oe;

endmodule

// >>> testbench/pmac_array_props.sv
`timescale 1ns/1ps
module pmac_array_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic        pin_oe_n_in,
    input wire logic        pin_oe_n_drv,
    input wire logic [7:0]  io_out,
    input wire logic [7:0]  io_oe
);
    logic [15:0] typ_reg;
    logic [1:0]  mode_reg;
    logic        sec_reg;
    logic [7:0]  cnt_reg, in_mask, reg_mask;
    wire         ctl_wr = bus_wr && bus_addr == 12'h000;
    wire         rd_st  = bus_rd && bus_addr == 12'h010;
    wire         oe_lvl = pin_oe_n_drv ? pin_oe_n_in : 1'b1;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the configuration, so that pin checks follow the cell types.
    always_ff @(posedge clk) begin
        if (reset) begin
            {typ_reg, mode_reg, sec_reg, cnt_reg} <= '0;
        end else begin
            if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
            if (bus_wr && bus_addr == 12'h004) typ_reg <= bus_wdata[15:0];
            if (ctl_wr && bus_wdata[1:0] != 2'h3) mode_reg <= bus_wdata[1:0];
            if (ctl_wr && bus_wdata[2]) sec_reg <= 1'b1;
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            in_mask[i]  = typ_reg[2*i+:2] == 2'h0
                       && !(mode_reg == 2'h2 && (i == 3 || i == 4));
            reg_mask[i] = typ_reg[2*i+:2] == 2'h1 && mode_reg == 2'h0;
        end
    end
    a_reset_pins: assert property (
        disable iff (1'b0) reset |=> io_oe == 8'h00 && io_out == 8'hFF)
        else $error("pins not idle after reset");
    a_input_quiet: assert property ((io_oe & $past(in_mask)) == 8'h00)
        else $error("input cell drives its pin");
    a_fuse_locked: assert property (
        bus_rd && bus_addr[11:8] == 4'h1 && sec_reg |=> bus_rdata == 32'h0)
        else $error("fuse word readable while secured");
    a_mode_status: assert property (
        rd_st |=> bus_rdata[19:18] == $past(mode_reg) && bus_rdata[16] == $past(sec_reg))
        else $error("status mode or secure bit wrong");
    a_hold_status: assert property (
        rd_st && cnt_reg < 8'hC7 |=> bus_rdata[17] && bus_rdata[7:0] == 8'h00)
        else $error("registers not held low in power-up hold");
    a_oe_follow: assert property (
        (io_oe & $past(reg_mask)) == ($past(oe_lvl) ? 8'h00 : $past(reg_mask)))
        else $error("registered enable does not follow pin 11");
    a_inner_drive: assert property ($past(mode_reg) == 2'h2 |-> io_oe[4:3] == 2'b11)
        else $error("inner cells not driving in simple mode");
    a_sig_upper: assert property (
        bus_rd && bus_addr[11:5] == 7'h10 |=> bus_rdata[31:8] == 24'h0)
        else $error("signature read has upper bits set");
    c_secured: cover property (bus_rd && bus_addr[11:8] == 4'h1 && sec_reg);
    c_simple: cover property (mode_reg == 2'h2);
    c_reg_drive: cover property ((io_oe & reg_mask) != 8'h00);
endmodule

bind pmac_array pmac_array_props u_props (.clk(clk), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pin_oe_n_in(pin_oe_n_in), .pin_oe_n_drv(pin_oe_n_drv), .io_out(io_out), .io_oe(io_oe));

// >>> testbench/pmac_board.sv
`timescale 1ns/1ps
module pmac_board (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pulse,
    input  wire logic oe_off,
    output logic      pin_clk_in,
    output logic      pin_oe_n_in
);
    // Pin 1 never moves unless asked, so no stray edge lands in the power-up hold.
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_clk_in  <= 1'b0;
            pin_oe_n_in <= 1'b0;
        end else begin
            pin_clk_in  <= pulse;
            pin_oe_n_in <= oe_off;
        end
    end
endmodule

// >>> testbench/tb_pmac_array.sv
`timescale 1ns/1ps
module tb_pmac_array;
    logic        clk, reset, bus_wr, bus_rd, pulse, oe_off, oe_drv, pin_clk_in, pin_oe_n_in;
    logic [11:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, got;
    logic [7:0]  ded_in, ded_drv, io_in, io_drv, io_out, io_oe;
    int          err_total, compares, mode_m, seed;
    int          sig_m[8];
    int          mseq[4] = '{1, 3, 2, 0};
    pmac_board u_board (.clk(clk), .reset(reset), .pulse(pulse), .oe_off(oe_off),
        .pin_clk_in(pin_clk_in), .pin_oe_n_in(pin_oe_n_in));
    pmac_array u_dut (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pin_clk_in(pin_clk_in),
        .pin_clk_drv(1'b1), .pin_oe_n_in(pin_oe_n_in), .pin_oe_n_drv(oe_drv), .ded_in(ded_in),
        .ded_drv(ded_drv), .io_in(io_in), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        ded_in <= 8'($random(seed));
        ded_drv <= 8'($random(seed));
        io_in <= 8'($random(seed));
        io_drv <= 8'($random(seed));
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 got = bus_rdata;
    endtask
    task automatic clk_pulse();
        @(posedge clk);
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    initial begin
        seed = 32'h60A184E0;
        mode_m = 0;
        {reset, bus_wr, bus_rd, pulse, oe_off, oe_drv} = 6'b100001;
        {bus_addr, bus_wdata} = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(12'h010);
        chk("status", 32'h0002_0000, got);
        chk("pins", 32'h0000_0000, {16'h0, io_out, io_oe});
        $display("test power_up done");
        for (int n = 0; n < 8; n++) begin
            sig_m[n] = $random(seed) & 255;
            wr(12'h200 + 12'(4 * n), 32'(sig_m[n]));
        end
        wr(12'h004, 32'h1);
        wr(12'h100, 32'h0);
        // A rise inside the hold must be ignored, so the register stays low.
        clk_pulse();
        rd(12'h010);
        chk("hold", 32'h0002_0100, got);
        chk("reg_pin", 32'h1, 32'(io_out[0]));
        repeat (200) @(posedge clk);
        clk_pulse();
        rd(12'h010);
        chk("capture", 32'h0000_0101, got);
        chk("io_out", 32'h0, 32'(io_out[0]));
        oe_off <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("io_oe", 32'h0, 32'(io_oe[0]));
        oe_off <= 1'b0;
        oe_drv <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("pull_up", 32'h0, 32'(io_oe[0]));
        oe_drv <= 1'b1;
        wr(12'h00C, 32'h0302);
        rd(12'h010);
        chk("preload", 32'h0000_0102, got);
        rd(12'h104);
        chk("fuse", 32'hFFFF_FFFF, got);
        $display("test registers done");
        wr(12'h000, 32'h4);
        rd(12'h104);
        chk("fuse_sec", 32'h0, got);
        wr(12'h00C, 32'h0301);
        rd(12'h010);
        chk("pre_sec", 32'h0001_0102, got);
        for (int n = 0; n < 8; n++) begin
            rd(12'h200 + 12'(4 * n));
            chk("sig", 32'(sig_m[n]), got);
        end
        $display("test security done");
        foreach (mseq[k]) begin
            wr(12'h000, 32'(mseq[k]));
            if (mseq[k] != 3) mode_m = mseq[k];
            rd(12'h010);
            chk("mode", 32'(mode_m), 32'(got[19:18]));
            chk("inner", mode_m == 2 ? 32'h3 : 32'h0, 32'(io_oe[4:3]));
        end
        $display("test modes done");
        print_verdict();
    end
endmodule
